//--- include/wpo_pkg.sv
// Package for the path overhead, delineation loss and counter block
package wpo_pkg;

    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned LCD_SET_TIME_US  = 3000;
    localparam int unsigned LCD_CLR_TIME_US  = 1000;
    // More than 3 ms: one cycle beyond the exact count
    localparam int unsigned LCD_SET_CYCLES   = (LCD_SET_TIME_US * (CLK_HZ / 1_000_000)) + 1;
    localparam int unsigned LCD_CLR_CYCLES   = LCD_CLR_TIME_US * (CLK_HZ / 1_000_000);

    localparam int unsigned CNT_WIDTH        = 32;
    localparam int unsigned TICK_DUR_WIDTH   = 32;
    localparam logic [7:0]  OCTET_RESET      = 8'h00;
    localparam logic [31:0] TICK_DUR_RESET   = 32'h0098_9680;

    // Counter indices
    localparam int unsigned CNT_SECTION      = 0;
    localparam int unsigned CNT_LINE         = 1;
    localparam int unsigned CNT_PATH         = 2;
    localparam int unsigned CNT_FAR_PATH     = 3;
    localparam int unsigned CNT_FAR_LINE     = 4;
    localparam int unsigned CNT_NUM          = 5;

    // Transmit overhead octet positions
    typedef enum logic [2:0]
    {
        WPO_OH_NONE = 3'b000,
        WPO_OH_H4   = 3'b001,
        WPO_OH_Z3   = 3'b010,
        WPO_OH_Z4   = 3'b011,
        WPO_OH_N1   = 3'b100
    } wpo_oh_sel_t;

    // Programmable transmit octets
    typedef struct packed
    {
        logic [7:0] multiframe;
        logic [7:0] growth_a;
        logic [7:0] growth_b;
        logic [7:0] tandem;
    } wpo_tx_octets_t;

    // Per frame error report from the parity checkers
    typedef struct packed
    {
        logic       frame_done;
        logic [7:0]  section_mismatch;
        logic [10:0] line_mismatch;
        logic [7:0]  path_mismatch;
        logic [3:0]  far_path_errors;
        logic [10:0] far_line_errors;
    } wpo_err_report_t;

    typedef enum logic [1:0]
    {
        WPO_LCD_RESET   = 2'b00,
        WPO_LCD_CLEAR   = 2'b01,
        WPO_LCD_DEFECT  = 2'b10
    } wpo_lcd_state_t;

endpackage

//--- verilog/wpo_sat_counter.sv
// Saturating statistical counter with tick snapshot
`timescale 1ns/100ps
module wpo_sat_counter
    import wpo_pkg::*;
#(
    parameter int unsigned WIDTH = CNT_WIDTH,
    parameter int unsigned INC_W = 11
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inc_valid,
    input  wire logic [INC_W-1:0] inc_amount,
    input  wire logic             tick,
    output logic      [WIDTH-1:0] snapshot
);

    logic [WIDTH-1:0] count;
    logic [WIDTH:0]   sum;
    logic [WIDTH-1:0] next_count;

    always_comb
    begin
        sum = {1'b0, count} + {{(WIDTH + 1 - INC_W){1'b0}}, inc_amount};
        if (!inc_valid)
            next_count = count;
        else if (sum[WIDTH])
            next_count = {WIDTH{1'b1}};
        else
            next_count = sum[WIDTH-1:0];
    end

    // Errors arriving with the tick go into both the snapshot and the new interval
    always_ff @(posedge clk)
    begin
        if (rst)
            count <= '0;
        else if (tick)
            count <= inc_valid ? {{(WIDTH - INC_W){1'b0}}, inc_amount} : '0;
        else
            count <= next_count;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            snapshot <= '0;
        else if (tick)
            snapshot <= next_count;
    end

endmodule // wpo_sat_counter

//--- verilog/wpo_path_overhead.sv
// Path overhead insertion, delineation loss handling and error counters
// Operation
// - Multiframe octet register is sent in the H4 slot of every frame.
// - Two growth octet registers are sent in the Z3 and Z4 slots.
// - Tandem octet register is sent in the N1 slot of every frame.
// - Received overhead is dropped; only payload goes to the coding sublayer.
// - Delineation alarm sets sticky status and pending bits; only pending is masked onto irqs.
// - Defect reported to far end after alarm persists more than 3 ms.
// - After reset, loss is reported until valid code groups are delineated.
// - Defect clears only after alarm absent continuously at least 1 ms.
// - Each error type has a read-latched standard and tick-latched statistic counter.
// - Upper half read first copies full standard count into readable pair.
// - Lower half read returns the half captured by the upper read.
// - Tick copies all statistic counts together, then restarts them from that cycle's errors.
// - Force bit makes a tick at once, regardless of tick enable.
// - Internal source with enable gives periodic ticks every programmed count.
// - Tick timer runs on the receive path clock, so period may drift.
// - External source with enable: rising edge on tick pin makes a tick.
// - Every tick sets a pending bit until read, masked onto both irqs.
// - Statistic counters saturate at maximum, never wrapping.
// - Block mode 0 counts each mismatching parity bit.
// - Block mode 1 counts one per frame with any mismatch.
// - Far-end path error counter is 32 bits, saturating, tick latched.
`timescale 1ns/100ps
module wpo_path_overhead
    import wpo_pkg::*;
#(
    parameter int unsigned SET_CYCLES = LCD_SET_CYCLES,
    parameter int unsigned CLR_CYCLES = LCD_CLR_CYCLES
)
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Transmit overhead
    input  wire wpo_tx_octets_t             tx_octets,
    input  wire wpo_oh_sel_t                tx_oh_slot,
    output logic [7:0]                      tx_oh_octet,
    output logic                            tx_oh_valid,
    // Receive payload
    input  wire logic [7:0]                 rx_octet,
    input  wire logic                       rx_octet_valid,
    input  wire logic                       rx_is_overhead,
    output logic [7:0]                      rx_payload,
    output logic                            rx_payload_valid,
    // Delineation loss
    input  wire logic                       pcs_delineation_alarm,
    input  wire logic                       delineation_loss_read,
    input  wire logic                       delineation_loss_mask_a,
    input  wire logic                       delineation_loss_mask_b,
    output logic                            delineation_loss_status,
    output logic                            delineation_loss_pending,
    output logic                            far_end_delineation_report,
    // Tick control
    input  wire logic                       tick_force_write,
    input  wire logic                       tick_enable,
    input  wire logic                       tick_source_select,
    input  wire logic [TICK_DUR_WIDTH-1:0]  tick_period_count,
    input  wire logic                       tick_pin,
    input  wire logic                       tick_pending_read,
    input  wire logic                       tick_mask_a,
    input  wire logic                       tick_mask_b,
    output logic                            tick_force,
    output logic                            tick_event_pending,
    output logic                            perf_monitor_tick,
    output logic                            irq_out_a,
    output logic                            irq_out_b,
    // Errors
    input  wire wpo_err_report_t            err_report,
    input  wire logic                       section_parity_block_mode,
    input  wire logic                       line_parity_block_mode,
    input  wire logic                       path_parity_block_mode,
    input  wire logic                       far_parity_block_mode,
    // Standard counter reads
    input  wire logic [2:0]                 std_read_index,
    input  wire logic                       std_read_upper,
    input  wire logic                       std_read_lower,
    output logic [15:0]                     std_read_data,
    // Statistic snapshots
    output logic [CNT_NUM*CNT_WIDTH-1:0]    stat_snapshots
);

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
            n = n + {3'b000, v[i]};
        return n;
    endfunction

    // Amount added for one frame, per accumulation mode
    function automatic logic [10:0] mode_amount(input logic blk, input logic [10:0] n);
        if (blk)
            return (n != 11'h000) ? 11'h001 : 11'h000;
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit overhead insertion

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_oh_octet <= OCTET_RESET;
            tx_oh_valid <= 1'b0;
        end
        else
        begin
            tx_oh_valid <= (tx_oh_slot != WPO_OH_NONE);
            case (tx_oh_slot)
                WPO_OH_H4: tx_oh_octet <= tx_octets.multiframe;
                WPO_OH_Z3: tx_oh_octet <= tx_octets.growth_a;
                WPO_OH_Z4: tx_oh_octet <= tx_octets.growth_b;
                WPO_OH_N1: tx_oh_octet <= tx_octets.tandem;
                default:   tx_oh_octet <= OCTET_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive overhead stripping

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_payload       <= 8'h00;
            rx_payload_valid <= 1'b0;
        end
        else
        begin
            rx_payload_valid <= rx_octet_valid && !rx_is_overhead;
            if (rx_octet_valid && !rx_is_overhead)
                rx_payload <= rx_octet;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Delineation loss defect

    wpo_lcd_state_t lcd_state;
    logic [31:0]    lcd_timer;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lcd_state <= WPO_LCD_RESET;
            lcd_timer <= '0;
        end
        else
        begin
            case (lcd_state)
                WPO_LCD_RESET:
                    if (!pcs_delineation_alarm)
                    begin
                        lcd_state <= WPO_LCD_CLEAR;
                        lcd_timer <= '0;
                    end
                WPO_LCD_CLEAR:
                    if (!pcs_delineation_alarm)
                        lcd_timer <= '0;
                    else if (lcd_timer + 32'h0000_0001 >= SET_CYCLES)
                    begin
                        lcd_state <= WPO_LCD_DEFECT;
                        lcd_timer <= '0;
                    end
                    else
                        lcd_timer <= lcd_timer + 32'h0000_0001;
                WPO_LCD_DEFECT:
                    if (pcs_delineation_alarm)
                        lcd_timer <= '0;
                    else if (lcd_timer + 32'h0000_0001 >= CLR_CYCLES)
                    begin
                        lcd_state <= WPO_LCD_CLEAR;
                        lcd_timer <= '0;
                    end
                    else
                        lcd_timer <= lcd_timer + 32'h0000_0001;
                default:
                begin
                    lcd_state <= WPO_LCD_RESET;
                    lcd_timer <= '0;
                end
            endcase
        end
    end

    assign far_end_delineation_report = (lcd_state != WPO_LCD_CLEAR);

    // Set wins over the read clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            delineation_loss_status  <= 1'b0;
            delineation_loss_pending <= 1'b0;
        end
        else
        begin
            delineation_loss_status  <= pcs_delineation_alarm
                                     || (delineation_loss_status && !delineation_loss_read);
            delineation_loss_pending <= pcs_delineation_alarm
                                     || (delineation_loss_pending && !delineation_loss_read);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Monitoring tick generation

    logic [TICK_DUR_WIDTH-1:0] tick_timer;
    logic                      tick_pin_prev;
    logic                      periodic_tick;
    logic                      pin_tick;

    // Timer shares clk, which is the recovered receive clock
    always_ff @(posedge clk)
    begin
        if (rst || !tick_enable || !tick_source_select)
            tick_timer <= '0;
        else if (periodic_tick)
            tick_timer <= '0;
        else
            tick_timer <= tick_timer + 32'h0000_0001;
    end

    // Zero period is treated as one cycle
    assign periodic_tick = tick_enable && tick_source_select
                        && (tick_timer + 32'h0000_0001 >= tick_period_count);

    always_ff @(posedge clk)
    begin
        if (rst)
            tick_pin_prev <= 1'b0;
        else
            tick_pin_prev <= tick_pin;
    end

    assign pin_tick = tick_enable && !tick_source_select && tick_pin && !tick_pin_prev;

    always_ff @(posedge clk)
    begin
        if (rst)
            tick_force <= 1'b0;
        else
            tick_force <= tick_force_write;
    end

    assign perf_monitor_tick = tick_force || periodic_tick || pin_tick;

    always_ff @(posedge clk)
    begin
        if (rst)
            tick_event_pending <= 1'b0;
        else
            tick_event_pending <= perf_monitor_tick
                               || (tick_event_pending && !tick_pending_read);
    end

    assign irq_out_a = (delineation_loss_pending && delineation_loss_mask_a)
                    || (tick_event_pending && tick_mask_a);
    assign irq_out_b = (delineation_loss_pending && delineation_loss_mask_b)
                    || (tick_event_pending && tick_mask_b);

    ////////////////////////////////////////////////////////////////////////////////
    // Error counters

    logic [10:0] inc [CNT_NUM];
    logic [CNT_WIDTH-1:0] std_count [CNT_NUM];
    logic [CNT_WIDTH-1:0] std_latched [CNT_NUM];

    always_comb
    begin
        inc[CNT_SECTION]  = mode_amount(section_parity_block_mode,
                                        {7'h00, ones8(err_report.section_mismatch)});
        inc[CNT_LINE]     = mode_amount(line_parity_block_mode, err_report.line_mismatch);
        inc[CNT_PATH]     = mode_amount(path_parity_block_mode,
                                        {7'h00, ones8(err_report.path_mismatch)});
        inc[CNT_FAR_PATH] = mode_amount(far_parity_block_mode,
                                        {7'h00, err_report.far_path_errors});
        inc[CNT_FAR_LINE] = err_report.far_line_errors;
    end

    for (genvar g = 0; g < CNT_NUM; g++)
    begin : g_cnt
        wpo_sat_counter #(.WIDTH(CNT_WIDTH), .INC_W(11)) u_stat
        (
            .clk        (clk),
            .rst        (rst),
            .inc_valid  (err_report.frame_done),
            .inc_amount (inc[g]),
            .tick       (perf_monitor_tick),
            .snapshot   (stat_snapshots[g*CNT_WIDTH +: CNT_WIDTH])
        );

        // Standard counter wraps freely and is independent of ticks
        always_ff @(posedge clk)
        begin
            if (rst)
                std_count[g] <= '0;
            else if (err_report.frame_done)
                std_count[g] <= std_count[g] + {21'h00_0000, inc[g]};
        end

        always_ff @(posedge clk)
        begin
            if (rst)
                std_latched[g] <= '0;
            else if (std_read_upper && (std_read_index == 3'(g)))
                std_latched[g] <= std_count[g];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            std_read_data <= 16'h0000;
        else if (std_read_index < 3'(CNT_NUM))
        begin
            if (std_read_upper)
                std_read_data <= std_count[std_read_index][31:16];
            else if (std_read_lower)
                std_read_data <= std_latched[std_read_index][15:0];
        end
        else if (std_read_upper || std_read_lower)
            std_read_data <= 16'h0000;
    end

endmodule // wpo_path_overhead

//--- test/wpo_path_overhead_sva.sv
// Concurrent checks on the path overhead block ports
`timescale 1ns/100ps
module wpo_path_overhead_sva
    import wpo_pkg::*;
#(
    parameter int unsigned SET_CYCLES = LCD_SET_CYCLES,
    parameter int unsigned CLR_CYCLES = LCD_CLR_CYCLES
)
(
    input wire logic           clk,
    input wire logic           rst,
    input wire wpo_tx_octets_t tx_octets,
    input wire wpo_oh_sel_t    tx_oh_slot,
    input wire logic [7:0]     tx_oh_octet,
    input wire logic [7:0]     rx_octet,
    input wire logic           rx_octet_valid,
    input wire logic           rx_is_overhead,
    input wire logic [7:0]     rx_payload,
    input wire logic           rx_payload_valid,
    input wire logic           pcs_delineation_alarm,
    input wire logic           delineation_loss_status,
    input wire logic           delineation_loss_pending,
    input wire logic           far_end_delineation_report,
    input wire logic           tick_force_write,
    input wire logic           tick_force,
    input wire logic           tick_enable,
    input wire logic           tick_source_select,
    input wire logic           tick_pin,
    input wire logic           perf_monitor_tick,
    input wire logic           tick_event_pending
);
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // Alarm run lengths; saturate so a long run never looks short
    always_ff @(posedge clk)
    begin
        if (rst || !pcs_delineation_alarm) hi_cnt <= '0;
        else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h0001;
    end
    always_ff @(posedge clk)
    begin
        if (rst || pcs_delineation_alarm) lo_cnt <= '0;
        else if (lo_cnt != 16'hFFFF) lo_cnt <= lo_cnt + 16'h0001;
    end
    property p_h4;
        tx_oh_slot == WPO_OH_H4 |=> tx_oh_octet == $past(tx_octets.multiframe);
    endproperty
    a_h4: assert property (p_h4) else $error("wrong multiframe octet");
    property p_rx;
        rx_payload_valid == $past(rx_octet_valid && !rx_is_overhead);
    endproperty
    a_rx: assert property (p_rx) else $error("payload strobe wrong");
    property p_lcd;
        pcs_delineation_alarm |=> delineation_loss_status && delineation_loss_pending;
    endproperty
    a_lcd: assert property (p_lcd) else $error("loss bits not set");
    property p_force;
        tick_force_write |=> tick_force && perf_monitor_tick ##1 !tick_force;
    endproperty
    a_force: assert property (p_force) else $error("forced tick wrong");
    property p_pend;
        perf_monitor_tick |=> tick_event_pending;
    endproperty
    a_pend: assert property (p_pend) else $error("tick pending not set");
    property p_pin;
        tick_enable && !tick_source_select && $rose(tick_pin) |-> perf_monitor_tick;
    endproperty
    a_pin: assert property (p_pin) else $error("pin edge gave no tick");
    property p_rst_rep;
        $fell(rst) |-> far_end_delineation_report;
    endproperty
    a_rst_rep: assert property (p_rst_rep) else $error("no report after reset");
    property p_set;
        $rose(far_end_delineation_report) |-> hi_cnt >= SET_CYCLES;
    endproperty
    a_set: assert property (p_set) else $error("report raised early");
    property p_clr;
        lo_cnt >= CLR_CYCLES |-> !far_end_delineation_report;
    endproperty
    a_clr: assert property (p_clr) else $error("report held too long");
endmodule // wpo_path_overhead_sva

bind wpo_path_overhead wpo_path_overhead_sva
    #(.SET_CYCLES(SET_CYCLES), .CLR_CYCLES(CLR_CYCLES)) u_sva (.*);

//--- test/wpo_station_mgr.sv
// Station manager model reading the standard counter pair
`timescale 1ns/100ps
module wpo_station_mgr
(
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic        lower_only,
    input  wire logic [2:0]  index,
    input  wire logic [15:0] std_read_data,
    output logic [2:0]       std_read_index,
    output logic             std_read_upper,
    output logic             std_read_lower,
    output logic [31:0]      value,
    output logic             done
);
    initial
    begin
        std_read_index = 3'h0;
        std_read_upper = 1'b0;
        std_read_lower = 1'b0;
        value = 32'h0000_0000;
        done = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Lone lower read only used to show the half stays latched
    always
    begin
        @(negedge clk);
        done <= 1'b0;
        if (go && !done)
        begin
            std_read_index <= index;
            if (!lower_only)
            begin
                std_read_upper <= 1'b1;
                @(negedge clk);
                std_read_upper <= 1'b0;
                value[31:16] <= std_read_data;
            end
            std_read_lower <= 1'b1;
            @(negedge clk);
            std_read_lower <= 1'b0;
            value[15:0] <= std_read_data;
            done <= 1'b1;
        end
    end
endmodule // wpo_station_mgr

//--- test/wpo_path_overhead_tb.sv
// Self-checking bench for the path overhead block
`timescale 1ns/100ps
module wpo_path_overhead_tb;
    import wpo_pkg::*;
    localparam int unsigned SET_N = 20;
    localparam int unsigned CLR_N = 10;
    logic clk = 1'b0;
    logic rst, tx_oh_valid, rx_octet_valid, rx_is_overhead, rx_payload_valid;
    logic [7:0] tx_oh_octet, rx_octet, rx_payload;
    wpo_tx_octets_t tx_octets;
    wpo_oh_sel_t tx_oh_slot;
    logic pcs_delineation_alarm, delineation_loss_read, delineation_loss_mask_a;
    logic delineation_loss_mask_b, delineation_loss_status, delineation_loss_pending;
    logic far_end_delineation_report, tick_force_write, tick_enable, tick_source_select;
    logic tick_pin, tick_pending_read, tick_mask_a, tick_mask_b, tick_force;
    logic tick_event_pending, perf_monitor_tick, irq_out_a, irq_out_b;
    logic [31:0] tick_period_count, value;
    wpo_err_report_t err_report;
    logic section_parity_block_mode, line_parity_block_mode;
    logic path_parity_block_mode, far_parity_block_mode;
    logic [2:0] std_read_index, index;
    logic std_read_upper, std_read_lower, go, lower_only, done;
    logic [15:0] std_read_data;
    logic [CNT_NUM*CNT_WIDTH-1:0] stat_snapshots;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int ticks = 0;
    int t0;
    wpo_path_overhead #(.SET_CYCLES(SET_N), .CLR_CYCLES(CLR_N)) uut (.*);
    wpo_station_mgr u_mgr (.*);
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////
    // Sampled before the edge's own updates land
    always @(posedge clk)
    begin
        cyc++;
        if (perf_monitor_tick === 1'b1) ticks++;
        if (cyc > 2000)
        begin
            failures++;
            final_report();
        end
    end
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1)
        begin
            failures++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task final_report();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task frame();
        err_report <= {1'b1, 8'h0F, 11'h005, 8'h81, 4'h6, 11'h007};
        step(1);
        err_report <= '0;
        step(1);
    endtask
    task force_tick();
        tick_force_write <= 1'b1;
        step(1);
        tick_force_write <= 1'b0;
        chk(tick_force === 1'b1 && perf_monitor_tick === 1'b1, "no forced tick");
        step(1);
        chk(tick_force === 1'b0, "force bit stuck");
    endtask
    task mgr_read(input logic [2:0] idx, input logic lone, input logic [31:0] exp);
        index <= idx;
        lower_only <= lone;
        go <= 1'b1;
        step(1);
        go <= 1'b0;
        for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
        step(1);
        chk(value === exp, "standard count wrong");
    endtask
    task t_tx();
        logic [7:0] exp [5];
        exp = '{8'h00, 8'hA5, 8'h3C, 8'h96, 8'h5A};
        tx_octets <= {8'hA5, 8'h3C, 8'h96, 8'h5A};
        for (int s = 0; s < 5; s++)
        begin
            tx_oh_slot <= wpo_oh_sel_t'(s);
            step(1);
            chk(tx_oh_octet === exp[s] && tx_oh_valid === (s != 0), "tx octet");
        end
        tx_oh_slot <= WPO_OH_NONE;
    endtask
    task t_rx();
        rx_octet_valid <= 1'b1;
        rx_is_overhead <= 1'b1;
        rx_octet <= 8'h11;
        step(1);
        chk(rx_payload_valid === 1'b0, "overhead passed on");
        rx_is_overhead <= 1'b0;
        rx_octet <= 8'h22;
        step(1);
        chk(rx_payload_valid === 1'b1 && rx_payload === 8'h22, "payload lost");
        rx_octet <= 8'h33;
        step(1);
        rx_octet_valid <= 1'b0;
        chk(rx_payload === 8'h33, "payload lost");
    endtask
    task t_lcd();
        pcs_delineation_alarm <= 1'b1;
        delineation_loss_mask_a <= 1'b1;
        step(SET_N - 5);
        chk(far_end_delineation_report === 1'b0, "early report");
        chk(irq_out_a === 1'b1 && irq_out_b === 1'b0, "irq masks");
        step(10);
        chk(far_end_delineation_report === 1'b1, "no report");
        pcs_delineation_alarm <= 1'b0;
        step(CLR_N - 5);
        pcs_delineation_alarm <= 1'b1;
        step(2);
        pcs_delineation_alarm <= 1'b0;
        step(CLR_N - 3);
        chk(far_end_delineation_report === 1'b1, "cleared early");
        step(10);
        chk(far_end_delineation_report === 1'b0, "not cleared");
        delineation_loss_read <= 1'b1;
        step(1);
        delineation_loss_read <= 1'b0;
        step(1);
        chk(delineation_loss_pending === 1'b0 && irq_out_a === 1'b0
            && delineation_loss_status === 1'b0, "not cleared");
    endtask
    task t_stat();
        repeat (2) frame();
        force_tick();
        chk(stat_snapshots === {32'd14, 32'd12, 32'd4, 32'd10, 32'd8}, "bit mode");
        {section_parity_block_mode, line_parity_block_mode} <= 2'b11;
        {path_parity_block_mode, far_parity_block_mode} <= 2'b11;
        repeat (2) frame();
        force_tick();
        chk(stat_snapshots === {32'd14, 32'd2, 32'd2, 32'd2, 32'd2}, "block mode");
        mgr_read(3'h4, 1'b0, 32'd28);
        frame();
        mgr_read(3'h4, 1'b1, 32'd28);
        mgr_read(3'h4, 1'b0, 32'd35);
        mgr_read(3'h0, 1'b0, 32'd11);
        mgr_read(3'h5, 1'b0, 32'd0);
    endtask
    task t_tick();
        tick_mask_b <= 1'b1;
        step(1);
        chk(tick_event_pending === 1'b1 && irq_out_b === 1'b1, "tick pending");
        tick_pending_read <= 1'b1;
        step(1);
        tick_pending_read <= 1'b0;
        step(1);
        chk(irq_out_b === 1'b0, "pending not cleared");
        tick_period_count <= 32'h0000_0005;
        {tick_source_select, tick_enable} <= 2'b11;
        step(3);
        t0 = ticks;
        step(50);
        chk(ticks - t0 == 10, "period count");
        tick_source_select <= 1'b0;
        step(2);
        t0 = ticks;
        tick_pin <= 1'b1;
        step(3);
        chk(ticks - t0 == 1, "pin tick");
        {tick_pin, tick_enable} <= 2'b00;
        step(2);
        tick_pin <= 1'b1;
        step(3);
        chk(ticks - t0 == 1, "tick while disabled");
    endtask
    initial
    begin
        rst = 1'b1;
        {tx_octets, rx_octet, rx_octet_valid, rx_is_overhead} = '0;
        tx_oh_slot = WPO_OH_NONE;
        pcs_delineation_alarm = 1'b1;
        {delineation_loss_read, delineation_loss_mask_a, delineation_loss_mask_b} = '0;
        {tick_force_write, tick_enable, tick_source_select, tick_pin} = '0;
        {tick_pending_read, tick_mask_a, tick_mask_b, tick_period_count} = '0;
        err_report = '0;
        {section_parity_block_mode, line_parity_block_mode} = '0;
        {path_parity_block_mode, far_parity_block_mode} = '0;
        {index, go, lower_only} = '0;
        step(4);
        rst <= 1'b0;
        step(3);
        chk(far_end_delineation_report === 1'b1, "no report after reset");
        pcs_delineation_alarm <= 1'b0;
        step(3);
        chk(far_end_delineation_report === 1'b0, "report stuck");
        t_tx();
        t_rx();
        t_lcd();
        t_stat();
        t_tick();
        final_report();
    end
endmodule // wpo_path_overhead_tb
